// File: rtl/vsr_defs.svh
// register indices, field positions, reset values and timing counts of the sync reference port
// assumes inclusion by bare name from the design module or the bench
`ifndef VSR_DEFS_SVH
`define VSR_DEFS_SVH
// register indices; byte address is four times the index
`define VSR_CFG_IDX 10'h06b
`define VSR_PULSE_IDX 10'h070
`define VSR_LINE_IDX 10'h071
`define VSR_CTRL_IDX 10'h072
`define VSR_STAT_IDX 10'h073
// sync_port_config fields
`define VSR_TYPE_LSB 6
`define VSR_HSRC_BIT 5
`define VSR_A_DIR_BIT 4
`define VSR_A_POL_BIT 3
`define VSR_COMPOSITE_BLANK_SELECT_BIT 2
`define VSR_B_DIR_BIT 1
`define VSR_B_POL_BIT 0
// pulse, line and control fields
`define VSR_START_LSB 0
`define VSR_END_LSB 16
`define VSR_FAL_LSB 0
`define VSR_LAL_LSB 16
`define VSR_HORIZONTAL_TRIGGER_PHASE_LSB 0
`define VSR_ESS_BIT 16
`define VSR_PAL_BIT 17
`define VSR_SECAM_BIT 18
// status fields
`define VSR_ST_LINE_LSB 16
`define VSR_ST_SEQ_LSB 26
`define VSR_ST_ODD_BIT 30
// reset values
`define VSR_CFG_RST 8'h00
`define VSR_START_RST 11'h000
`define VSR_END_RST 11'h080
`define VSR_FAL_RST 10'h017
`define VSR_LAL_RST 10'h136
`define VSR_HORIZONTAL_TRIGGER_PHASE_RST 11'h000
`define VSR_PAL_RST 1'b1
// port a type codes
`define VSR_TYPE_VS 2'h0
`define VSR_TYPE_FS 2'h1
`define VSR_TYPE_FIELD_SEQUENCE_SYNC 2'h2
// timing counts
`define VSR_H_LAST 11'h6bf
`define VSR_LINES_625 10'h139
`define VSR_LINES_525 10'h107
`define VSR_VS_LINES 10'h003
`define VSR_SEQ_NTSC 4'h4
`define VSR_SEQ_PAL 4'h8
`define VSR_SEQ_SECAM 4'hc
`endif

// File: rtl/vsr_pkg.sv
// types shared by the sync reference port and its surroundings
// assumes vsr_defs.svh holds all numeric constants
package vsr_pkg;
	// one driven sync pin: level and active-low output enable
	typedef struct packed {
		logic level;
		logic oe_n;
	} vsr_pin_type;
	// internal timing handed to the encoder core
	typedef struct packed {
		logic [10:0] h_pos;
		logic [9:0] line;
		logic odd_field;
		logic blank;
	} vsr_timing_type;
endpackage

// File: rtl/vsr_sync_port.sv
// sync reference port: two sync pins, apb register file, line and field timing
// assumes pclk is the pixel clock, embedded sync pulses come from logic on pclk
// Overview of operation
// - type field picks vsync, frame or sequence
// - sequence sync every 4, 8, 12 fields
// - hsync from pin a, embedded, or pin b
// - bit 4 sets pin a direction
// - bit 3 sets pin a polarity or edge
// - pin b output gives horizontal reference pulse
// - pin b input used for hsync and, in blanking mode without embedded sync, for internal blank
// - blanking mode pulse suppressed in vertical blanking
// - blanking mode input also drives internal blank while embedded sync is off
// - bit 1 sets pin b direction
// - bit 0 sets pin b polarity or edge
// - horizontal timing aligned to edge plus phase
`include "vsr_defs.svh"
module vsr_sync_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_port_a_in,
	output vsr_pkg::vsr_pin_type sync_port_a,
	input wire logic sync_port_b_in,
	output vsr_pkg::vsr_pin_type sync_port_b,
	input wire logic embedded_hsync,
	input wire logic embedded_vsync,
	output vsr_pkg::vsr_timing_type timing
);
	// software registers
	logic [7:0] cfg_reg, cfg_next; // sync_port_config
	logic [10:0] start_reg, start_next; // port_b_pulse_start
	logic [10:0] end_reg, end_next; // port_b_pulse_end
	logic [9:0] fal_reg, fal_next; // first_active_line
	logic [9:0] lal_reg, lal_next; // last_active_line
	logic [10:0] horizontal_trigger_phase_reg, horizontal_trigger_phase_next; // horizontal_trigger_phase
	logic ess_reg, ess_next; // embedded_sync_select
	logic pal_reg, pal_next;
	logic secam_reg, secam_next;
	logic [31:0] prdata_reg, prdata_next;
	// pin synchronisers and filtered levels
	logic [2:0] a_pipe_reg, a_pipe_next;
	logic [2:0] b_pipe_reg, b_pipe_next;
	logic a_lvl_reg, a_lvl_next, a_prev_reg, a_prev_next;
	logic b_lvl_reg, b_lvl_next, b_prev_reg, b_prev_next;
	// timing state
	logic [10:0] hcount_reg, hcount_next;
	logic [9:0] line_reg, line_next;
	logic [3:0] seq_reg, seq_next;
	logic odd_reg, odd_next;
	// registered pin and timing outputs
	vsr_pkg::vsr_pin_type a_out_reg, a_out_next, b_out_reg, b_out_next;
	vsr_pkg::vsr_timing_type tim_reg, tim_next;
	// decoded config and events
	logic [1:0] a_type;
	logic hsrc, a_dir, a_pol, composite_blank_select, b_dir, b_pol;
	logic a_edge, b_edge, h_edge, v_edge, line_end, field_adv;
	logic [3:0] seq_len;
	logic [9:0] field_lines;
	logic a_active, b_window, b_active, in_active_lines;
	logic access, hit, wr_en, setup;
	logic [9:0] idx;

	assign a_type = cfg_reg[`VSR_TYPE_LSB +: 2];
	assign hsrc = cfg_reg[`VSR_HSRC_BIT];
	assign a_dir = cfg_reg[`VSR_A_DIR_BIT];
	assign a_pol = cfg_reg[`VSR_A_POL_BIT];
	assign composite_blank_select = cfg_reg[`VSR_COMPOSITE_BLANK_SELECT_BIT];
	assign b_dir = cfg_reg[`VSR_B_DIR_BIT];
	assign b_pol = cfg_reg[`VSR_B_POL_BIT];

	// apb decode; zero wait states, so pready follows penable
	assign idx = paddr[11:2];
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign hit = (paddr[1:0] == 2'h0) && ((idx == `VSR_CFG_IDX) || (idx == `VSR_PULSE_IDX) ||
		(idx == `VSR_LINE_IDX) || (idx == `VSR_CTRL_IDX) || (idx == `VSR_STAT_IDX));
	assign wr_en = access & pwrite & hit;
	assign pready = access;
	assign pslverr = access & ~hit; // unmapped address answers with an error
	assign prdata = prdata_reg;

	// register writes; status register is read-only, writes to it are dropped
	always_comb begin
		cfg_next = cfg_reg;
		start_next = start_reg;
		end_next = end_reg;
		fal_next = fal_reg;
		lal_next = lal_reg;
		horizontal_trigger_phase_next = horizontal_trigger_phase_reg;
		ess_next = ess_reg;
		pal_next = pal_reg;
		secam_next = secam_reg;
		if (wr_en) begin
			case (idx)
				`VSR_CFG_IDX: cfg_next = pwdata[7:0];
				`VSR_PULSE_IDX: begin
					start_next = pwdata[`VSR_START_LSB +: 11];
					end_next = pwdata[`VSR_END_LSB +: 11];
				end
				`VSR_LINE_IDX: begin
					fal_next = pwdata[`VSR_FAL_LSB +: 10];
					lal_next = pwdata[`VSR_LAL_LSB +: 10];
				end
				`VSR_CTRL_IDX: begin
					horizontal_trigger_phase_next = pwdata[`VSR_HORIZONTAL_TRIGGER_PHASE_LSB +: 11];
					ess_next = pwdata[`VSR_ESS_BIT];
					pal_next = pwdata[`VSR_PAL_BIT];
					secam_next = pwdata[`VSR_SECAM_BIT];
				end
				default: cfg_next = cfg_reg;
			endcase
		end
	end

	// read data captured in the setup cycle so it comes from a flop in the access cycle
	always_comb begin
		prdata_next = prdata_reg;
		if (setup) begin
			case (idx)
				`VSR_CFG_IDX: prdata_next = {24'h000000, cfg_reg};
				`VSR_PULSE_IDX: prdata_next = {5'h00, end_reg, 5'h00, start_reg};
				`VSR_LINE_IDX: prdata_next = {6'h00, lal_reg, 6'h00, fal_reg};
				`VSR_CTRL_IDX: prdata_next = {13'h0000, secam_reg, pal_reg, ess_reg, 5'h00, horizontal_trigger_phase_reg};
				`VSR_STAT_IDX: prdata_next = {1'b0, odd_reg, seq_reg, line_reg, 5'h00, hcount_reg};
				default: prdata_next = 32'h00000000;
			endcase
			// an unaligned address matches a register index but must still read zero
			if (paddr[1:0] != 2'h0) begin
				prdata_next = 32'h00000000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `VSR_CFG_RST;
			start_reg <= `VSR_START_RST;
			end_reg <= `VSR_END_RST;
			fal_reg <= `VSR_FAL_RST;
			lal_reg <= `VSR_LAL_RST;
			horizontal_trigger_phase_reg <= `VSR_HORIZONTAL_TRIGGER_PHASE_RST;
			ess_reg <= 1'b0;
			pal_reg <= `VSR_PAL_RST;
			secam_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			cfg_reg <= cfg_next;
			start_reg <= start_next;
			end_reg <= end_next;
			fal_reg <= fal_next;
			lal_reg <= lal_next;
			horizontal_trigger_phase_reg <= horizontal_trigger_phase_next;
			ess_reg <= ess_next;
			pal_reg <= pal_next;
			secam_reg <= secam_next;
			prdata_reg <= prdata_next;
		end
	end

	// pin synchronisers: level accepted once stages two and three agree
	always_comb begin
		a_pipe_next = {a_pipe_reg[1:0], sync_port_a_in};
		b_pipe_next = {b_pipe_reg[1:0], sync_port_b_in};
		a_lvl_next = (a_pipe_reg[1] == a_pipe_reg[2]) ? a_pipe_reg[2] : a_lvl_reg;
		b_lvl_next = (b_pipe_reg[1] == b_pipe_reg[2]) ? b_pipe_reg[2] : b_lvl_reg;
		a_prev_next = a_lvl_reg;
		b_prev_next = b_lvl_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_pipe_reg <= 3'h0;
			b_pipe_reg <= 3'h0;
			a_lvl_reg <= 1'b0;
			b_lvl_reg <= 1'b0;
			a_prev_reg <= 1'b0;
			b_prev_reg <= 1'b0;
		end else begin
			a_pipe_reg <= a_pipe_next;
			b_pipe_reg <= b_pipe_next;
			a_lvl_reg <= a_lvl_next;
			b_lvl_reg <= b_lvl_next;
			a_prev_reg <= a_prev_next;
			b_prev_reg <= b_prev_next;
		end
	end

	// active edge per polarity: rising when clear, falling when set
	assign a_edge = a_pol ? (a_prev_reg & ~a_lvl_reg) : (a_lvl_reg & ~a_prev_reg);
	assign b_edge = b_pol ? (b_prev_reg & ~b_lvl_reg) : (b_lvl_reg & ~b_prev_reg);
	// hsync source; with both select bits set the embedded sync still wins
	assign h_edge = ess_reg ? embedded_hsync : (hsrc ? b_edge : a_edge);
	// vertical reference only taken from pin a while it is an input
	assign v_edge = ess_reg ? embedded_vsync : (~a_dir & a_edge);
	assign line_end = (hcount_reg == `VSR_H_LAST);
	assign seq_len = secam_reg ? `VSR_SEQ_SECAM : (pal_reg ? `VSR_SEQ_PAL : `VSR_SEQ_NTSC);
	assign field_lines = pal_reg ? `VSR_LINES_625 : `VSR_LINES_525;
	// field runs free only while the device makes vertical timing itself
	assign field_adv = v_edge | (line_end & a_dir & (line_reg == field_lines - 10'h001));

	// line and field counters; hsync edge reloads the phase value
	always_comb begin
		hcount_next = line_end ? 11'h000 : hcount_reg + 11'h001;
		line_next = line_end ? line_reg + 10'h001 : line_reg;
		seq_next = seq_reg;
		odd_next = odd_reg;
		if (h_edge) begin
			hcount_next = horizontal_trigger_phase_reg;
		end
		if (field_adv) begin
			line_next = 10'h000;
			odd_next = ~odd_reg;
			seq_next = (seq_reg >= seq_len - 4'h1) ? 4'h0 : seq_reg + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcount_reg <= 11'h000;
			line_reg <= 10'h000;
			seq_reg <= 4'h0;
			odd_reg <= 1'b0;
		end else begin
			hcount_reg <= hcount_next;
			line_reg <= line_next;
			seq_reg <= seq_next;
			odd_reg <= odd_next;
		end
	end

	// pin a content by type; type 11 just holds the inactive level
	always_comb begin
		case (a_type)
			`VSR_TYPE_VS: a_active = (line_reg < `VSR_VS_LINES);
			`VSR_TYPE_FS: a_active = odd_reg;
			`VSR_TYPE_FIELD_SEQUENCE_SYNC: a_active = (line_reg < `VSR_VS_LINES) && (seq_reg == 4'h0);
			default: a_active = 1'b0;
		endcase
	end

	assign b_window = (hcount_reg >= start_reg) && (hcount_reg < end_reg);
	assign in_active_lines = (line_reg >= fal_reg) && (line_reg <= lal_reg);
	// reference pulse runs through vertical blanking unless blanking mode is on
	assign b_active = b_window & (~composite_blank_select | in_active_lines);

	// registered pin drive and timing outputs
	always_comb begin
		a_out_next.level = a_active ^ a_pol;
		a_out_next.oe_n = ~a_dir;
		b_out_next.level = b_active ^ b_pol;
		b_out_next.oe_n = ~b_dir;
		tim_next.h_pos = hcount_reg;
		tim_next.line = line_reg;
		tim_next.odd_field = odd_reg;
		// external blanking input only honoured in blanking mode as input, no embedded sync
		if (composite_blank_select & ~b_dir & ~ess_reg) begin
			tim_next.blank = ~(b_lvl_reg ^ b_pol);
		end else begin
			tim_next.blank = ~in_active_lines;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_out_reg <= 2'b01;
			b_out_reg <= 2'b01;
			tim_reg <= '0;
		end else begin
			a_out_reg <= a_out_next;
			b_out_reg <= b_out_next;
			tim_reg <= tim_next;
		end
	end

	assign sync_port_a = a_out_reg;
	assign sync_port_b = b_out_reg;
	assign timing = tim_reg;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// pin a content checks
	vsync_each_field_a: assert property (a_type == `VSR_TYPE_VS && line_reg < `VSR_VS_LINES
		|=> sync_port_a.level != $past(a_pol))
		else $error("pin a vsync not active in first lines");
	field_sequence_sync_quiet_a: assert property (a_type == `VSR_TYPE_FIELD_SEQUENCE_SYNC && seq_reg != 4'h0
		|=> sync_port_a.level == $past(a_pol))
		else $error("pin a sequence sync active in wrong field");
	seq_wrap_a: assert property (field_adv && seq_reg == seq_len - 4'h1 && !wr_en |=> seq_reg == 4'h0)
		else $error("field sequence did not wrap at its length");
	// horizontal source and phase checks
	hsrc_pin_a: assert property (!ess_reg && !hsrc && a_edge |=> hcount_reg == $past(horizontal_trigger_phase_reg))
		else $error("pin a edge did not reload horizontal phase");
	hsrc_pin_b_a: assert property (!ess_reg && hsrc && b_edge |=> hcount_reg == $past(horizontal_trigger_phase_reg))
		else $error("pin b edge did not reload horizontal phase");
	b_ignored_a: assert property (!ess_reg && !hsrc && b_edge && !a_edge && !line_end
		|=> hcount_reg == $past(hcount_reg) + 11'h001)
		else $error("pin b input disturbed timing while not selected");
	// direction writes reach the pins two edges later
	a_dir_write_a: assert property (wr_en && idx == `VSR_CFG_IDX && pwdata[`VSR_A_DIR_BIT]
		|-> ##2 !sync_port_a.oe_n)
		else $error("pin a not driven after direction write");
	b_dir_write_a: assert property (wr_en && idx == `VSR_CFG_IDX && !pwdata[`VSR_B_DIR_BIT]
		|-> ##2 sync_port_b.oe_n)
		else $error("pin b still driven after input write");
	rise_edge_a: assert property (!a_pol && !ess_reg && !hsrc && $rose(a_lvl_reg)
		|=> hcount_reg == $past(horizontal_trigger_phase_reg))
		else $error("rising edge not taken on pin a");
	// pin b output and blanking checks
	horizontal_reference_pulse_pulse_a: assert property (!composite_blank_select && b_window |=> sync_port_b.level != $past(b_pol))
		else $error("horizontal reference pulse missing");
	cblank_vbi_a: assert property (composite_blank_select && line_reg < fal_reg |=> sync_port_b.level == $past(b_pol))
		else $error("blanking pulse present in vertical blanking");
	blank_input_a: assert property (composite_blank_select && !b_dir && !ess_reg
		|=> timing.blank == !($past(b_lvl_reg) ^ $past(b_pol)))
		else $error("internal blank does not follow pin b input");
	b_low_idle_a: assert property (b_pol && !b_window |=> sync_port_b.level)
		else $error("active-low pin b not idle high");
	// reference pulse must not be cut by the blanking lines while blanking mode is off
	horizontal_reference_pulse_vbi_a: assert property (!composite_blank_select && b_window && line_reg < fal_reg
		|=> sync_port_b.level != $past(b_pol))
		else $error("horizontal reference pulse cut in vertical blanking");
	fs_odd_out_a: assert property (a_type == `VSR_TYPE_FS
		|=> sync_port_a.level == ($past(odd_reg) ^ $past(a_pol)))
		else $error("pin a frame sync does not follow odd field");
	emb_hsync_a: assert property (ess_reg && embedded_hsync |=> hcount_reg == $past(horizontal_trigger_phase_reg))
		else $error("embedded sync did not reload horizontal phase");
	cfg_write_a: assert property (wr_en && idx == `VSR_CFG_IDX |=> cfg_reg == $past(pwdata[7:0]))
		else $error("config write not taken");

	// main scenarios
	field_sequence_sync_pulse_c: cover property (a_type == `VSR_TYPE_FIELD_SEQUENCE_SYNC && seq_reg == 4'h0 && line_reg == 10'h000);
	horizontal_reference_pulse_out_c: cover property (b_dir && !composite_blank_select && b_window);
	embedded_c: cover property (ess_reg && embedded_hsync);
	slverr_c: cover property (pslverr);
endmodule

// File: verif/vsr_video_src.sv
// video source model facing both sync pins of the encoder
// assumes the bench sets the levels it wants on each pin
module vsr_video_src (
	input wire logic a_drive,
	input wire logic b_drive,
	input wire vsr_pkg::vsr_pin_type a_pin,
	input wire vsr_pkg::vsr_pin_type b_pin,
	output logic a_wire,
	output logic b_wire
);
	// the source lets go of a pin while the encoder enables it
	always_comb begin
		a_wire = a_pin.oe_n ? a_drive : a_pin.level;
		b_wire = b_pin.oe_n ? b_drive : b_pin.level;
	end
endmodule

// File: verif/video_sync_reference_port_tb.sv
// self-checking bench of the sync port over apb and both sync pins
// assumes the video source model and a 20 MHz pixel clock
`include "vsr_defs.svh"
module video_sync_reference_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] CFG = {`VSR_CFG_IDX, 2'b00};
	localparam logic [11:0] PUL = {`VSR_PULSE_IDX, 2'b00};
	localparam logic [11:0] LIN = {`VSR_LINE_IDX, 2'b00};
	localparam logic [11:0] CTL = {`VSR_CTRL_IDX, 2'b00};
	localparam logic [11:0] STA = {`VSR_STAT_IDX, 2'b00};
	logic pclk = 1'b0; // pixel clock
	logic presetn = 1'b0; // held low at start
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, a_wire, b_wire;
	logic a_drv = 1'b0, b_drv = 1'b0, emb_h = 1'b0, emb_v = 1'b0; // source levels
	vsr_pkg::vsr_pin_type sync_port_a, sync_port_b;
	vsr_pkg::vsr_timing_type timing;
	int err_total = 0, n_tests = 0;
	always #25 pclk = ~pclk;
	vsr_sync_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sync_port_a_in(a_wire), .sync_port_a(sync_port_a), .sync_port_b_in(b_wire),
		.sync_port_b(sync_port_b), .embedded_hsync(emb_h), .embedded_vsync(emb_v), .timing(timing));
	vsr_video_src src_u (.a_drive(a_drv), .b_drive(b_drv), .a_pin(sync_port_a), .b_pin(sync_port_b),
		.a_wire(a_wire), .b_wire(b_wire));
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		cmp(rd, exp);
	endtask
	task automatic drv(input int w, input logic v);
		@(posedge pclk);
		if (w == 0) a_drv <= v;
		else b_drv <= v;
	endtask
	// is the horizontal counter less than 0x40 clocks past the trigger phase 0x123
	task automatic hcheck(input logic e);
		logic [11:0] d;
		cyc(40);
		xfer(STA, 1'b0, 32'h0);
		d = {1'b0, rd[10:0]} + 12'h6c0 - 12'h123;
		if (d >= 12'h6c0) d = d - 12'h6c0;
		cmp({31'h0, d < 12'h040}, {31'h0, e});
	endtask
	// idle, active edge, then inactive edge which never aligns
	task automatic probe(input int w, input logic p, input logic e);
		drv(w, p);
		cyc(600);
		drv(w, ~p);
		hcheck(e);
		cyc(600);
		drv(w, p);
		hcheck(1'b0);
	endtask
	// active cycles of pin b over exactly one line
	task automatic bcount(input logic p, input logic [31:0] exp);
		logic [31:0] c;
		c = 32'h0;
		cyc(3);
		cmp({31'h0, sync_port_b.oe_n}, 32'h0);
		repeat (12'h6c0) begin
			@(posedge pclk);
			if (sync_port_b.level === ~p) c++;
		end
		cmp(c, exp);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#4500000;
		err_total++;
		test_done;
	end
	initial begin
		cyc(8);
		presetn <= 1'b1;
		rchk(CFG, 32'h0);
		rchk(PUL, 32'h0080_0000);
		rchk(LIN, 32'h0136_0017);
		rchk(CTL, 32'h0002_0000);
		xfer(12'h1d0, 1'b0, 32'h0);
		cmp({31'h0, er}, 32'h1);
		cmp(rd, 32'h0);
		// unaligned access to a mapped index is refused and reads zero
		xfer(12'h1ae, 1'b0, 32'h0);
		cmp({31'h0, er}, 32'h1);
		cmp(rd, 32'h0);
		wr(12'h1ad, 32'h000000ff);
		rchk(CFG, 32'h0);
		// pin a driven in line 0 shows the vertical pulse
		wr(CFG, 32'h10);
		cyc(3);
		cmp({30'h0, sync_port_a}, 32'h2);
		wr(CFG, 32'h18);
		cyc(3);
		cmp({30'h0, sync_port_a}, 32'h0);
		while (sync_port_a.level !== 1'b1) begin
			@(posedge pclk);
		end
		xfer(STA, 1'b0, 32'h0);
		cmp({22'h0, rd[25:16]}, 32'h3);
		wr(CFG, 32'h0);
		cyc(3);
		cmp({31'h0, sync_port_a.oe_n}, 32'h1);
		for (int t = 0; t < 3; t++) begin
			wr(CFG, 32'(t) << 6);
			rchk(CFG, 32'(t) << 6);
		end
		// pin b output pulse, polarity and blanking window
		wr(PUL, 32'h0200_0100);
		wr(CFG, 32'h02);
		bcount(1'b0, 32'h100);
		wr(CFG, 32'h03);
		bcount(1'b1, 32'h100);
		wr(LIN, 32'h0200_0201);
		wr(CFG, 32'h06);
		bcount(1'b0, 32'h0);
		wr(LIN, 32'h03ff_0000);
		bcount(1'b0, 32'h100);
		// horizontal alignment to the chosen source
		wr(CTL, 32'h0002_0123);
		wr(CFG, 32'h0);
		probe(0, 1'b0, 1'b1);
		wr(CFG, 32'h08);
		probe(0, 1'b1, 1'b1);
		probe(1, 1'b0, 1'b0);
		wr(CFG, 32'h20);
		probe(1, 1'b0, 1'b1);
		wr(CFG, 32'h21);
		probe(1, 1'b1, 1'b1);
		wr(CFG, 32'h25);
		probe(1, 1'b1, 1'b1);
		cmp({31'h0, timing.blank}, 32'h1);
		drv(1, 1'b0);
		cyc(8);
		cmp({31'h0, timing.blank}, 32'h0);
		drv(1, 1'b1);
		wr(CTL, 32'h0003_0123);
		wr(CFG, 32'h20);
		probe(1, 1'b0, 1'b0);
		wr(CFG, 32'h0);
		@(posedge pclk);
		emb_h <= 1'b1;
		@(posedge pclk);
		emb_h <= 1'b0;
		hcheck(1'b1);
		// field sequence length per standard: ntsc, pal, secam
		drv(0, 1'b0);
		for (int s = 0; s < 3; s++) begin
			presetn <= 1'b0;
			cyc(8);
			presetn <= 1'b1;
			wr(CTL, 32'(s) << 17);
			for (int k = 1; k <= 4 * s + 4; k++) begin
				drv(0, 1'b1);
				cyc(10);
				drv(0, 1'b0);
				cyc(10);
				if (k >= 4 * s + 3) begin
					xfer(STA, 1'b0, 32'h0);
					cmp({28'h0, rd[29:26]}, 32'(k % (4 * s + 4)));
					cmp({31'h0, timing.odd_field}, 32'(k % 2));
				end
			end
		end
		test_done;
	end
endmodule
